// ===== core/cmpu_cfg_if.sv
// carrier between the protection register store and the checker
`timescale 1ns/1ps
interface cmpu_cfg_if;
  import cmpu_pkg::*;
  logic we;
  logic set;
  cmpu_idx_t idx;
  cmpu_word_t wdata;
  cmpu_word_t words [CMPU_SETS][CMPU_WORDS_N];

  modport regs (
    input we,
    input set,
    input idx,
    input wdata,
    output words
  );
  modport chk (
    output we,
    output set,
    output idx,
    output wdata,
    input words
  );
endinterface

// ===== core/cmpu_pkg.sv
// constants and types shared by the memory protection unit
package cmpu_pkg;

  // ***********************************
  // widths and counts
  // ***********************************
  localparam int CMPU_AW = 32;
  localparam int CMPU_SETS = 2;
  localparam int CMPU_DRANGES = 4;
  localparam int CMPU_CRANGES = 2;
  localparam int CMPU_WORDS_N = 14;

  typedef logic [CMPU_AW-1:0] cmpu_word_t;
  typedef logic [3:0] cmpu_idx_t;
  typedef logic [2:0] cmpu_class_t;

  // ***********************************
  // word layout of one protection set
  // ***********************************
  localparam int CMPU_IDX_DBND = 0;
  localparam int CMPU_IDX_CBND = 8;
  localparam int CMPU_IDX_DMODE = 12;
  localparam int CMPU_IDX_CMODE = 13;
  localparam cmpu_idx_t CMPU_WORDS = 4'hE;

  // ***********************************
  // mode register fields
  // ***********************************
  localparam int CMPU_DMODE_STRIDE = 2;
  localparam int CMPU_DMODE_RD = 0;
  localparam int CMPU_DMODE_WR = 1;
  localparam int CMPU_CMODE_STRIDE = 1;
  localparam int CMPU_CMODE_EX = 0;

  // ***********************************
  // trap class bits and reset value
  // ***********************************
  localparam int CMPU_CLS_FETCH = 0;
  localparam int CMPU_CLS_READ = 1;
  localparam int CMPU_CLS_WRITE = 2;
  localparam cmpu_word_t CMPU_WORD_RST = 32'h0000_0000;

endpackage

// ===== core/cmpu_prot_regs.sv
// storage for both protection register sets
`timescale 1ns/1ps
module cmpu_prot_regs (
  input wire logic clk,
  input wire logic reset,
  cmpu_cfg_if.regs cfg
);
  import cmpu_pkg::*;

  cmpu_word_t mem_r [CMPU_SETS][CMPU_WORDS_N];
  cmpu_word_t mem_nxt [CMPU_SETS][CMPU_WORDS_N];

  // ***********************************
  // write port
  // ***********************************
  always_comb begin
    mem_nxt = mem_r;
    if (cfg.we && (cfg.idx < CMPU_WORDS)) begin
      mem_nxt[cfg.set][cfg.idx] = cfg.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int s = 0; s < CMPU_SETS; s++) begin
        for (int w = 0; w < CMPU_WORDS_N; w++) begin
          mem_r[s][w] <= CMPU_WORD_RST;
        end
      end
    end else begin
      mem_r <= mem_nxt;
    end
  end

  assign cfg.words = mem_r;

endmodule

// ===== core/cmpu_protection_unit.sv
// memory protection checker for code fetches and data accesses
// How it works
// - two independent protection sets, 0 and 1, each cover code and data.
// - the status word set-select field picks the set that checks accesses.
// - each set has a data part for data accesses and a code part for fetches.
// - the data part holds four ranges, each with its own mode.
// - the code part holds two ranges for fetch protection.
// - each range is bounded by a pair of registers, lower and upper.
// - each part has one mode register giving the modes of its ranges.
// - read and write permission are judged separately for each data range.
// - an illegal access raises a trap toward the trap handler routine.
// - an illegal access is also signalled to the debug unit with its address; the data address wins when fetch and data both trap in one cycle.
`timescale 1ns/1ps
module cmpu_protection_unit (
  input wire logic clk,
  input wire logic reset,
  input wire logic cfg_we,
  input wire logic cfg_set,
  input wire cmpu_pkg::cmpu_idx_t cfg_idx,
  input wire cmpu_pkg::cmpu_word_t cfg_wdata,
  input wire logic status_word_protection_set_select,
  input wire logic fetch_req,
  input wire cmpu_pkg::cmpu_word_t fetch_addr,
  input wire logic data_req,
  input wire logic data_we,
  input wire cmpu_pkg::cmpu_word_t data_addr,
  input wire cmpu_pkg::cmpu_word_t data_wdata,
  output logic mem_fetch_req,
  output cmpu_pkg::cmpu_word_t mem_fetch_addr,
  output logic mem_data_req,
  output logic mem_data_we,
  output cmpu_pkg::cmpu_word_t mem_data_addr,
  output cmpu_pkg::cmpu_word_t mem_data_wdata,
  output logic trap_handler_routine_req,
  output cmpu_pkg::cmpu_class_t trap_class,
  output logic dbg_illegal,
  output cmpu_pkg::cmpu_word_t dbg_addr
);
  import cmpu_pkg::*;

  function automatic logic cmpu_in_range(
    input cmpu_word_t a,
    input cmpu_word_t lo,
    input cmpu_word_t hi
  );
    return (a >= lo) && (a < hi);
  endfunction

  // ***********************************
  // register store
  // ***********************************
  cmpu_cfg_if cfg ();

  assign cfg.we = cfg_we;
  assign cfg.set = cfg_set;
  assign cfg.idx = cfg_idx;
  assign cfg.wdata = cfg_wdata;

  cmpu_prot_regs u_regs (
    .clk(clk),
    .reset(reset),
    .cfg(cfg)
  );

  // ***********************************
  // range decode of the active set
  // ***********************************
  cmpu_word_t act [CMPU_WORDS_N];
  cmpu_word_t dmode;
  cmpu_word_t cmode;
  logic [CMPU_DRANGES-1:0] d_hit;
  logic [CMPU_DRANGES-1:0] d_rd_ok;
  logic [CMPU_DRANGES-1:0] d_wr_ok;
  logic [CMPU_CRANGES-1:0] c_hit;
  logic [CMPU_CRANGES-1:0] c_ok;
  logic data_legal;
  logic fetch_legal;

  assign act = cfg.words[status_word_protection_set_select];
  assign dmode = act[CMPU_IDX_DMODE];
  assign cmode = act[CMPU_IDX_CMODE];

  for (genvar k = 0; k < CMPU_DRANGES; k++) begin : g_data
    assign d_hit[k] = cmpu_in_range(data_addr,
      act[CMPU_IDX_DBND+2*k], act[CMPU_IDX_DBND+2*k+1]);
    assign d_rd_ok[k] = d_hit[k]
      & dmode[CMPU_DMODE_STRIDE*k+CMPU_DMODE_RD];
    assign d_wr_ok[k] = d_hit[k]
      & dmode[CMPU_DMODE_STRIDE*k+CMPU_DMODE_WR];
  end

  for (genvar k = 0; k < CMPU_CRANGES; k++) begin : g_code
    assign c_hit[k] = cmpu_in_range(fetch_addr,
      act[CMPU_IDX_CBND+2*k], act[CMPU_IDX_CBND+2*k+1]);
    assign c_ok[k] = c_hit[k]
      & cmode[CMPU_CMODE_STRIDE*k+CMPU_CMODE_EX];
  end

  assign data_legal = data_we ? (|d_wr_ok) : (|d_rd_ok);
  assign fetch_legal = |c_ok;

  // ***********************************
  // access forwarding and trap
  // ***********************************
  logic mem_fetch_req_r, mem_fetch_req_nxt;
  cmpu_word_t mem_fetch_addr_r, mem_fetch_addr_nxt;
  logic mem_data_req_r, mem_data_req_nxt;
  logic mem_data_we_r, mem_data_we_nxt;
  cmpu_word_t mem_data_addr_r, mem_data_addr_nxt;
  cmpu_word_t mem_data_wdata_r, mem_data_wdata_nxt;
  logic trap_r, trap_nxt;
  cmpu_class_t class_r, class_nxt;
  logic dbg_r, dbg_nxt;
  cmpu_word_t dbg_addr_r, dbg_addr_nxt;

  always_comb begin
    mem_fetch_req_nxt = fetch_req & fetch_legal;
    mem_fetch_addr_nxt = fetch_addr;
    mem_data_req_nxt = data_req & data_legal;
    mem_data_we_nxt = data_we;
    mem_data_addr_nxt = data_addr;
    mem_data_wdata_nxt = data_wdata;
    class_nxt = '0;
    class_nxt[CMPU_CLS_FETCH] = fetch_req & ~fetch_legal;
    class_nxt[CMPU_CLS_READ] = data_req & ~data_we & ~data_legal;
    class_nxt[CMPU_CLS_WRITE] = data_req & data_we & ~data_legal;
    trap_nxt = |class_nxt;
    dbg_nxt = |class_nxt;
    dbg_addr_nxt = dbg_addr_r;
    if (data_req && !data_legal) begin
      dbg_addr_nxt = data_addr;
    end else if (fetch_req && !fetch_legal) begin
      dbg_addr_nxt = fetch_addr;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mem_fetch_req_r <= 1'b0;
      mem_fetch_addr_r <= CMPU_WORD_RST;
      mem_data_req_r <= 1'b0;
      mem_data_we_r <= 1'b0;
      mem_data_addr_r <= CMPU_WORD_RST;
      mem_data_wdata_r <= CMPU_WORD_RST;
      trap_r <= 1'b0;
      class_r <= '0;
      dbg_r <= 1'b0;
      dbg_addr_r <= CMPU_WORD_RST;
    end else begin
      mem_fetch_req_r <= mem_fetch_req_nxt;
      mem_fetch_addr_r <= mem_fetch_addr_nxt;
      mem_data_req_r <= mem_data_req_nxt;
      mem_data_we_r <= mem_data_we_nxt;
      mem_data_addr_r <= mem_data_addr_nxt;
      mem_data_wdata_r <= mem_data_wdata_nxt;
      trap_r <= trap_nxt;
      class_r <= class_nxt;
      dbg_r <= dbg_nxt;
      dbg_addr_r <= dbg_addr_nxt;
    end
  end

  assign mem_fetch_req = mem_fetch_req_r;
  assign mem_fetch_addr = mem_fetch_addr_r;
  assign mem_data_req = mem_data_req_r;
  assign mem_data_we = mem_data_we_r;
  assign mem_data_addr = mem_data_addr_r;
  assign mem_data_wdata = mem_data_wdata_r;
  assign trap_handler_routine_req = trap_r;
  assign trap_class = class_r;
  assign dbg_illegal = dbg_r;
  assign dbg_addr = dbg_addr_r;

  // ***********************************
  // checks
  // ***********************************
  a_fetch_blocked: assert property (
    @(posedge clk) disable iff (reset)
    class_r[CMPU_CLS_FETCH] |-> !mem_fetch_req_r)
    else $error("trapped fetch reached memory");

  a_data_blocked: assert property (
    @(posedge clk) disable iff (reset)
    (class_r[CMPU_CLS_READ] | class_r[CMPU_CLS_WRITE]) |-> !mem_data_req_r)
    else $error("trapped data access reached memory");

  a_fetch_answered: assert property (
    @(posedge clk) disable iff (reset)
    fetch_req |=> (mem_fetch_req_r ^ class_r[CMPU_CLS_FETCH]))
    else $error("fetch neither forwarded nor trapped");

  a_data_answered: assert property (
    @(posedge clk) disable iff (reset)
    data_req |=> (mem_data_req_r
      ^ (class_r[CMPU_CLS_READ] | class_r[CMPU_CLS_WRITE])))
    else $error("data access neither forwarded nor trapped");

  a_debug_follows: assert property (
    @(posedge clk) disable iff (reset)
    trap_r |-> dbg_illegal && (class_r != '0)
      && (dbg_addr_r == ((class_r[CMPU_CLS_READ] | class_r[CMPU_CLS_WRITE])
      ? $past(data_addr) : $past(fetch_addr))))
    else $error("trap without debug indication");

  a_write_needs_mode: assert property (
    @(posedge clk) disable iff (reset)
    (mem_data_req_r && mem_data_we_r) |-> $past(|d_wr_ok))
    else $error("write forwarded without write permission");

  a_fetch_needs_mode: assert property (
    @(posedge clk) disable iff (reset)
    mem_fetch_req_r |-> $past(|c_ok)
      && (mem_fetch_addr_r == $past(fetch_addr)))
    else $error("fetch forwarded without permission");

  a_no_spurious: assert property (
    @(posedge clk) disable iff (reset)
    (!fetch_req && !data_req) |=> !trap_r && !mem_fetch_req_r
      && !mem_data_req_r)
    else $error("output without a request");

endmodule

// ===== testbench/cmpu_cpu_model.sv
// cpu side model issuing code fetches and data accesses
`timescale 1ns/1ps
module cmpu_cpu_model (
  input wire logic clk,
  output logic fetch_req,
  output cmpu_pkg::cmpu_word_t fetch_addr,
  output logic data_req,
  output logic data_we,
  output cmpu_pkg::cmpu_word_t data_addr,
  output cmpu_pkg::cmpu_word_t data_wdata
);
  import cmpu_pkg::*;
  initial begin
    fetch_req = 1'h0;
    fetch_addr = 32'h0;
    data_req = 1'h0;
    data_we = 1'h0;
    data_addr = 32'h0;
    data_wdata = 32'h0;
  end
  // ***********************************
  // one request cycle, then lines released
  // ***********************************
  task automatic issue(input logic f, d, we, input cmpu_word_t fa, da);
    @(posedge clk);
    fetch_req <= f;
    fetch_addr <= fa;
    data_req <= d;
    data_we <= we;
    data_addr <= da;
    data_wdata <= ~da;
    @(posedge clk);
    fetch_req <= 1'h0;
    data_req <= 1'h0;
    fetch_addr <= ~fa;
    data_addr <= ~da;
    data_wdata <= da;
    data_we <= ~we;
  endtask
endmodule

// ===== testbench/cmpu_protection_unit_tb.sv
// testbench for the memory protection unit
`timescale 1ns/1ps
module cmpu_protection_unit_tb;
  import cmpu_pkg::*;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic cfg_we = 1'h0;
  logic cfg_set = 1'h0;
  cmpu_idx_t cfg_idx = 4'h0;
  cmpu_word_t cfg_wdata = 32'h0;
  logic sel = 1'h0;
  logic fetch_req, data_req, data_we, mf, md, mwe, trap, dill;
  cmpu_word_t fetch_addr, data_addr, data_wdata, mfa, mda, mwd, dbga;
  cmpu_class_t cls;
  int n_fail = 0;
  int comparisons = 0;
  cmpu_word_t last_bad = 32'h0;
  always #2.5 clk = ~clk;
  cmpu_cpu_model cpu (.clk(clk), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .data_req(data_req), .data_we(data_we),
    .data_addr(data_addr), .data_wdata(data_wdata));
  cmpu_protection_unit dut (.clk(clk), .reset(reset), .cfg_we(cfg_we),
    .cfg_set(cfg_set), .cfg_idx(cfg_idx), .cfg_wdata(cfg_wdata),
    .status_word_protection_set_select(sel), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .data_req(data_req), .data_we(data_we),
    .data_addr(data_addr), .data_wdata(data_wdata), .mem_fetch_req(mf),
    .mem_fetch_addr(mfa), .mem_data_req(md), .mem_data_we(mwe),
    .mem_data_addr(mda), .mem_data_wdata(mwd),
    .trap_handler_routine_req(trap), .trap_class(cls),
    .dbg_illegal(dill), .dbg_addr(dbga));
  // ***********************************
  // shared tasks
  // ***********************************
  task automatic chk(input cmpu_word_t got, input cmpu_word_t exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("fails %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cfgw(input logic s, input cmpu_idx_t i, input cmpu_word_t v);
    @(posedge clk);
    cfg_we <= 1'h1;
    cfg_set <= s;
    cfg_idx <= i;
    cfg_wdata <= v;
    @(posedge clk);
    cfg_we <= 1'h0;
    cfg_wdata <= ~v;
  endtask
  // c holds the expected trap class, zero for a legal access
  task automatic acc(input logic f, d, we, input cmpu_word_t fa, da,
                     input cmpu_class_t c);
    logic mr;
    mr = d & ~c[1] & ~c[2];
    if (|c)
      last_bad = (c[1] | c[2]) ? da : fa;
    cpu.issue(f, d, we, fa, da);
    #1;
    chk(mf, f & ~c[0]);
    chk(md, mr);
    chk(trap, |c);
    chk(dill, |c);
    chk(cls, c);
    chk(dbga, last_bad);
    if (mr) begin
      chk(mda, da);
      chk(mwd, ~da);
      chk(mwe, we);
    end
    if (f & ~c[0])
      chk(mfa, fa);
  endtask
  // ***********************************
  // scenarios
  // ***********************************
  task automatic t_reset;
    acc(0, 1, 0, 32'h0, 32'h0000_1000, 3'h2);
    acc(1, 1, 1, 32'h0000_8000, 32'h0000_1000, 3'h5);
  endtask
  task automatic setup;
    cfgw(0, 4'h0, 32'h0000_1000);
    cfgw(0, 4'h1, 32'h0000_2000);
    cfgw(0, 4'h2, 32'h0000_3000);
    cfgw(0, 4'h3, 32'h0000_4000);
    cfgw(0, 4'h4, 32'h0000_7000);
    cfgw(0, 4'h5, 32'h0000_7100);
    cfgw(0, 4'h6, 32'h0000_5000);
    cfgw(0, 4'h7, 32'h0000_6000);
    cfgw(0, 4'h8, 32'h0000_A000);
    cfgw(0, 4'h9, 32'h0000_B000);
    cfgw(0, 4'hA, 32'h0000_8000);
    cfgw(0, 4'hB, 32'h0000_9000);
    cfgw(0, 4'hC, 32'h0000_00D9);
    cfgw(0, 4'hD, 32'h0000_0002);
    cfgw(1, 4'h0, 32'h0000_1000);
    cfgw(1, 4'h1, 32'h0000_2000);
    cfgw(1, 4'h8, 32'h0000_8000);
    cfgw(1, 4'h9, 32'h0000_9000);
    cfgw(1, 4'hC, 32'h0000_0002);
    cfgw(1, 4'hD, 32'h0000_0001);
  endtask
  task automatic t_data;
    acc(0, 1, 0, 32'h0, 32'h0000_1000, 3'h0);
    acc(0, 1, 0, 32'h0, 32'h0000_1FFF, 3'h0);
    acc(0, 1, 0, 32'h0, 32'h0000_2000, 3'h2);
    acc(0, 1, 1, 32'h0, 32'h0000_1800, 3'h4);
    acc(0, 1, 1, 32'h0, 32'h0000_3000, 3'h0);
    acc(0, 1, 0, 32'h0, 32'h0000_3FFC, 3'h2);
    acc(0, 1, 1, 32'h0, 32'h0000_5000, 3'h0);
    acc(0, 1, 0, 32'h0, 32'h0000_5FFF, 3'h0);
    acc(0, 1, 0, 32'h0, 32'h0000_0FFF, 3'h2);
    acc(0, 1, 0, 32'h0, 32'h0000_7000, 3'h0);
    acc(0, 1, 1, 32'h0, 32'h0000_70FF, 3'h4);
  endtask
  task automatic t_code;
    acc(1, 0, 0, 32'h0000_8000, 32'h0, 3'h0);
    acc(1, 0, 0, 32'h0000_1000, 32'h0, 3'h1);
    acc(1, 1, 0, 32'h0000_8FFC, 32'h0000_1000, 3'h0);
    acc(1, 1, 0, 32'h0000_9000, 32'h0000_2000, 3'h3);
    acc(1, 0, 0, 32'h0000_A000, 32'h0, 3'h1);
  endtask
  task automatic t_set;
    @(posedge clk);
    sel <= 1'h1;
    acc(0, 1, 1, 32'h0, 32'h0000_1000, 3'h0);
    acc(0, 1, 0, 32'h0, 32'h0000_1000, 3'h2);
    acc(1, 0, 0, 32'h0000_8000, 32'h0, 3'h0);
    acc(0, 1, 1, 32'h0, 32'h0000_3000, 3'h4);
    @(posedge clk);
    sel <= 1'h0;
    acc(0, 1, 1, 32'h0, 32'h0000_1000, 3'h4);
  endtask
  task automatic t_rerst;
    @(posedge clk);
    reset <= 1'h1;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    last_bad = 32'h0;
    #1;
    chk(dbga, last_bad);
    chk(trap, 1'h0);
    acc(0, 1, 0, 32'h0, 32'h0000_1000, 3'h2);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    t_reset;
    setup;
    t_data;
    t_code;
    t_set;
    t_rerst;
    close_out;
  end
  initial begin
    #20000;
    n_fail++;
    close_out;
  end
endmodule
